//--- hdl/iox_pkg.sv
// Shared constants and carrier types for the dual-port I/O expander core
package iox_pkg;

    // Width of every register
    localparam int REG_W = 8;

    // Register indices; byte address is four times the index, bit 6 selects the second port
    localparam logic [3:0] IDX_DIR = 4'h0;
    localparam logic [3:0] IDX_IEN = 4'h1;
    localparam logic [3:0] IDX_DEF = 4'h2;
    localparam logic [3:0] IDX_SRC = 4'h3;
    localparam logic [3:0] IDX_CFG = 4'h4;
    localparam logic [3:0] IDX_PU = 4'h6;
    localparam logic [3:0] IDX_FLAG = 4'h7;
    localparam logic [3:0] IDX_CAP = 4'h8;
    localparam logic [3:0] IDX_LVL = 4'h9;
    localparam logic [3:0] IDX_LAT = 4'ha;

    // Byte address layout
    localparam int ADR_PORT_POS = 6;
    localparam int ADR_IDX_LSB = 2;
    localparam int ADR_MAP_TOP = 7;

    // Field positions in device_config
    localparam int CFG_COMB_POS = 6;
    localparam int CFG_ODR_POS = 2;
    localparam int CFG_POL_POS = 1;

    // Reset values (pin_direction: 1 = input)
    localparam logic [REG_W-1:0] RST_DIR = 8'hff;
    localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
    localparam logic [REG_W-1:0] RST_CFG = 8'h00;

    // Nominal weak pull-up value in kilo-ohm, for the pad model
    localparam int PULLUP_KOHM = 100;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } iox_wb_req_s;

endpackage : iox_pkg

//--- hdl/iox_port_irq.sv
// Two 8-bit ports with change interrupts, reached over a Wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module iox_port_irq #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    // Wishbone slave
    input wire iox_pkg::iox_wb_req_s WB_REQ,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Port pins, first port in the low half
    input wire logic [2*WIDTH-1:0] PIN_IN,
    output logic [2*WIDTH-1:0] PIN_OUT,
    output logic [2*WIDTH-1:0] PIN_OE,
    output logic [2*WIDTH-1:0] PULLUP_EN,
    // Interrupt pins
    output logic IRQ_A_OUT,
    output logic IRQ_A_OE,
    output logic IRQ_B_OUT,
    output logic IRQ_B_OE
);
    import iox_pkg::*;

    // Registers are REG_W wide, so ports wider than that cannot be served
    if (WIDTH < 1 || WIDTH > REG_W) begin : g_bad_width
        $error("WIDTH must lie between 1 and REG_W");
    end

    // Per-port storage
    logic [WIDTH-1:0] dir_q [2];
    logic [WIDTH-1:0] ien_q [2];
    logic [WIDTH-1:0] def_q [2];
    logic [WIDTH-1:0] src_q [2];
    logic [WIDTH-1:0] pu_q [2];
    logic [WIDTH-1:0] lat_q [2];
    logic [WIDTH-1:0] sync1_q [2];
    logic [WIDTH-1:0] sync2_q [2];
    logic [WIDTH-1:0] ref_q [2];
    logic [WIDTH-1:0] flag_q [2];
    logic [WIDTH-1:0] cap_q [2];
    logic [WIDTH-1:0] cond_w [2];
    logic [1:0] pend_q;
    logic [1:0] clr_w;
    logic [REG_W-1:0] cfg_q;
    logic ack_q;
    logic act_a_q;
    logic act_b_q;

    // Bus decode
    logic req;
    logic in_map;
    logic psel;
    logic [3:0] ridx;
    logic wr_stb;
    logic rd_done;

    // Reads a port register, zero above WIDTH
    function automatic logic [REG_W-1:0] widen(input logic [WIDTH-1:0] v);
        logic [REG_W-1:0] r;
        r = RST_ZERO;
        r[WIDTH-1:0] = v;
        return r;
    endfunction : widen

    // Index and range check on the byte address
    assign req = WB_REQ.cyc & WB_REQ.stb;
    assign in_map = (WB_REQ.adr[31:ADR_MAP_TOP] == '0) && (WB_REQ.adr[1:0] == 2'h0);
    assign psel = WB_REQ.adr[ADR_PORT_POS];
    assign ridx = WB_REQ.adr[ADR_PORT_POS-1:ADR_IDX_LSB];
    // Writes and read side effects land on the edge where the master sees ack
    assign wr_stb = req & ack_q & WB_REQ.we & WB_REQ.sel[0] & in_map;
    assign rd_done = req & ack_q & ~WB_REQ.we & in_map;

    // Ack one cycle after the request, dropped the cycle after; unmapped reads give zero
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data is sampled together with raising ack
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            WB_DAT_O <= 32'h0000_0000;
            if (in_map) begin
                unique case (ridx)
                    IDX_DIR: WB_DAT_O[REG_W-1:0] <= widen(dir_q[psel]);
                    IDX_IEN: WB_DAT_O[REG_W-1:0] <= widen(ien_q[psel]);
                    IDX_DEF: WB_DAT_O[REG_W-1:0] <= widen(def_q[psel]);
                    IDX_SRC: WB_DAT_O[REG_W-1:0] <= widen(src_q[psel]);
                    IDX_CFG: WB_DAT_O[REG_W-1:0] <= cfg_q;
                    IDX_PU: WB_DAT_O[REG_W-1:0] <= widen(pu_q[psel]);
                    IDX_FLAG: WB_DAT_O[REG_W-1:0] <= widen(flag_q[psel] & ien_q[psel]);
                    IDX_CAP: WB_DAT_O[REG_W-1:0] <= widen(cap_q[psel]);
                    IDX_LVL: WB_DAT_O[REG_W-1:0] <= widen(sync2_q[psel]);
                    IDX_LAT: WB_DAT_O[REG_W-1:0] <= widen(lat_q[psel]);
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign WB_ACK_O = ack_q;

    // Shared configuration, visible at the same index from either port
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cfg_q <= RST_CFG;
        end else if (wr_stb && ridx == IDX_CFG) begin
            cfg_q <= WB_REQ.dat[REG_W-1:0];
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        // Software-written port registers; flag and capture have no write path
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                dir_q[p] <= RST_DIR[WIDTH-1:0];
                ien_q[p] <= RST_ZERO[WIDTH-1:0];
                def_q[p] <= RST_ZERO[WIDTH-1:0];
                src_q[p] <= RST_ZERO[WIDTH-1:0];
                pu_q[p] <= RST_ZERO[WIDTH-1:0];
                lat_q[p] <= RST_ZERO[WIDTH-1:0];
            end else if (wr_stb && psel == p) begin
                unique case (ridx)
                    IDX_DIR: dir_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_IEN: ien_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_DEF: def_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_SRC: src_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_PU: pu_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_LVL: lat_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    IDX_LAT: lat_q[p] <= WB_REQ.dat[WIDTH-1:0];
                    default: ;
                endcase
            end
        end

        // Two-stage pin synchroniser; only the second stage feeds logic
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                sync1_q[p] <= RST_ZERO[WIDTH-1:0];
                sync2_q[p] <= RST_ZERO[WIDTH-1:0];
            end else begin
                sync1_q[p] <= PIN_IN[p*WIDTH +: WIDTH];
                sync2_q[p] <= sync1_q[p];
            end
        end

        // Qualifying mismatch: enabled input pins only, source chosen per pin
        assign cond_w[p] = ien_q[p] & dir_q[p] &
            ((src_q[p] & (sync2_q[p] ^ def_q[p])) |
            (~src_q[p] & (sync2_q[p] ^ ref_q[p])));

        // A delivered read of capture or level clears this port
        assign clr_w[p] = rd_done && psel == p && (ridx == IDX_CAP || ridx == IDX_LVL);

        // Raise, hold and clear; a mismatch present at the clear wins over it
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                pend_q[p] <= 1'b0;
                flag_q[p] <= RST_ZERO[WIDTH-1:0];
                cap_q[p] <= RST_ZERO[WIDTH-1:0];
                ref_q[p] <= RST_ZERO[WIDTH-1:0];
            end else if (!pend_q[p] || clr_w[p]) begin
                if (|cond_w[p]) begin
                    pend_q[p] <= 1'b1;
                    flag_q[p] <= cond_w[p];
                    cap_q[p] <= sync2_q[p];
                    ref_q[p] <= sync2_q[p];
                end else begin
                    pend_q[p] <= 1'b0;
                    flag_q[p] <= RST_ZERO[WIDTH-1:0];
                    ref_q[p] <= sync2_q[p];
                end
            end
        end

        // Pin drivers; pull-up is withheld from output pins
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                PIN_OUT[p*WIDTH +: WIDTH] <= RST_ZERO[WIDTH-1:0];
                PIN_OE[p*WIDTH +: WIDTH] <= RST_ZERO[WIDTH-1:0];
                PULLUP_EN[p*WIDTH +: WIDTH] <= RST_ZERO[WIDTH-1:0];
            end else begin
                PIN_OUT[p*WIDTH +: WIDTH] <= lat_q[p];
                PIN_OE[p*WIDTH +: WIDTH] <= ~dir_q[p];
                PULLUP_EN[p*WIDTH +: WIDTH] <= pu_q[p] & dir_q[p];
            end
        end
    end

    // Routing of the two port signals onto the outputs
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            act_a_q <= 1'b0;
            act_b_q <= 1'b0;
        end else if (cfg_q[CFG_COMB_POS]) begin
            act_a_q <= pend_q[0] | pend_q[1];
            act_b_q <= pend_q[0] | pend_q[1];
        end else begin
            act_a_q <= pend_q[0];
            act_b_q <= pend_q[1];
        end
    end

    // Output stage; open-drain pulls low when active and floats otherwise
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            IRQ_A_OUT <= 1'b1;
            IRQ_A_OE <= 1'b1;
            IRQ_B_OUT <= 1'b1;
            IRQ_B_OE <= 1'b1;
        end else if (cfg_q[CFG_ODR_POS]) begin
            IRQ_A_OUT <= 1'b0;
            IRQ_A_OE <= act_a_q;
            IRQ_B_OUT <= 1'b0;
            IRQ_B_OE <= act_b_q;
        end else begin
            IRQ_A_OUT <= act_a_q ~^ cfg_q[CFG_POL_POS];
            IRQ_A_OE <= 1'b1;
            IRQ_B_OUT <= act_b_q ~^ cfg_q[CFG_POL_POS];
            IRQ_B_OE <= 1'b1;
        end
    end

    // Checks, all in the core clock domain
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_raise0;
        (!pend_q[0] || clr_w[0]) && (|cond_w[0]);
    endsequence

    sequence s_captured0;
        pend_q[0] && cap_q[0] == $past(sync2_q[0]);
    endsequence

    chk_ack_single_pulse: assert property (ack_q |=> !ack_q)
        else $error("ack stayed high two cycles");
    chk_ack_after_req: assert property (req && !ack_q |=> ack_q)
        else $error("request not acked in one cycle");
    chk_flag_write_ignored: assert property (
        wr_stb && ridx == IDX_FLAG && pend_q[0] |=> $stable(flag_q[0]) && pend_q[0])
        else $error("flag write disturbed interrupt state");
    chk_capture_on_raise: assert property (s_raise0 |=> s_captured0)
        else $error("capture missed the raise");
    chk_capture_held: assert property (
        pend_q[0] && !clr_w[0] |=> pend_q[0] && $stable(cap_q[0]))
        else $error("capture changed while pending");
    chk_clear_on_read: assert property (
        clr_w[0] && cond_w[0] == '0 |=> !pend_q[0])
        else $error("read did not clear interrupt");
    chk_disabled_quiet: assert property (
        !pend_q[0] && (ien_q[0] & dir_q[0]) == '0 |=> !pend_q[0])
        else $error("disabled pins raised interrupt");
    chk_combine_both: assert property (
        cfg_q[CFG_COMB_POS] && pend_q[0] |=> act_a_q && act_b_q)
        else $error("combined outputs not both active");
    chk_separate_route: assert property (
        !cfg_q[CFG_COMB_POS] && !pend_q[1] |=> !act_b_q)
        else $error("second output active without its port");
    chk_open_drain: assert property (
        cfg_q[CFG_ODR_POS] && act_a_q |=> IRQ_A_OE && !IRQ_A_OUT)
        else $error("open-drain output not pulling low");
    chk_latch_to_pin: assert property (
        wr_stb && !psel && ridx == IDX_LAT ##1 1'b1 |=>
        PIN_OUT[WIDTH-1:0] == $past(lat_q[0]))
        else $error("latch not driven to pins");

    // Port 1 runs the same raise, hold and clear logic as port 0
    sequence s_raise1;
        (!pend_q[1] || clr_w[1]) && (|cond_w[1]);
    endsequence

    sequence s_captured1;
        pend_q[1] && cap_q[1] == $past(sync2_q[1]);
    endsequence

    chk_capture_raise_b: assert property (s_raise1 |=> s_captured1)
        else $error("second port capture missed the raise");
    chk_capture_held_b: assert property (
        pend_q[1] && !clr_w[1] |=> pend_q[1] && $stable(cap_q[1]))
        else $error("second port capture changed while pending");
    chk_clear_read_b: assert property (
        clr_w[1] && cond_w[1] == '0 |=> !pend_q[1])
        else $error("read did not clear second port");

    // Capture moves only at a raise; a mismatch standing at the clear recaptures at once
    chk_capture_only_raise: assert property (
        !((!pend_q[0] || clr_w[0]) && (|cond_w[0])) |=> $stable(cap_q[0]))
        else $error("capture moved without a raise");
    chk_recapture_clear: assert property (
        clr_w[0] && cond_w[0] != '0 |=> pend_q[0] && cap_q[0] == $past(sync2_q[0]))
        else $error("pending change not recaptured at clear");
    chk_reference_reset: assert property (
        pend_q[0] && clr_w[0] |=> ref_q[0] == $past(sync2_q[0]))
        else $error("change reference not reset at clear");
    chk_default_persist: assert property (
        clr_w[1] && (ien_q[1] & dir_q[1] & src_q[1] & (sync2_q[1] ^ def_q[1])) != '0
        |=> pend_q[1])
        else $error("default mismatch dropped at read");
    chk_flag_needs_pending: assert property (
        flag_q[0] != '0 |-> pend_q[0])
        else $error("flag bit set without pending interrupt");
    // Writes carry we, so they can never reach the clear path
    chk_write_no_clear: assert property (
        wr_stb && pend_q[0] |=> pend_q[0])
        else $error("write cleared a pending interrupt");

    // Routing: each port alone, or the OR of both held until both are read
    chk_separate_own: assert property (
        !cfg_q[CFG_COMB_POS] |=> act_a_q == $past(pend_q[0]))
        else $error("first output not following its port");
    chk_separate_own_b: assert property (
        !cfg_q[CFG_COMB_POS] |=> act_b_q == $past(pend_q[1]))
        else $error("second output not following its port");
    chk_combine_from_b: assert property (
        cfg_q[CFG_COMB_POS] && pend_q[1] |=> act_a_q && act_b_q)
        else $error("combined outputs not both active for second port");
    // The next bus transfer is at least two cycles away, so the other port stays pending
    chk_combine_wait: assert property (
        cfg_q[CFG_COMB_POS] && pend_q[0] && pend_q[1] && clr_w[0] && !clr_w[1]
        |-> ##2 act_a_q && act_b_q)
        else $error("combined outputs dropped after one read");

    // Pin drivers and interrupt pin drive
    chk_pullup_inputs: assert property (
        1'b1 |=> PULLUP_EN[WIDTH-1:0] == $past(pu_q[0] & dir_q[0]))
        else $error("pull-up reached an output pin");
    chk_output_enable: assert property (
        1'b1 |=> PIN_OE[WIDTH-1:0] == $past(~dir_q[0]))
        else $error("pin drive does not follow direction");
    chk_push_pull: assert property (
        !cfg_q[CFG_ODR_POS] |=> IRQ_A_OE &&
        IRQ_A_OUT == $past(act_a_q ~^ cfg_q[CFG_POL_POS]))
        else $error("push-pull level wrong for polarity");

    // Only byte lane 0 carries data; the upper lanes read as zero
    chk_read_upper_zero: assert property (
        ack_q |-> WB_DAT_O[31:REG_W] == '0)
        else $error("upper read data lanes not zero");

endmodule : iox_port_irq

`default_nettype wire

//--- verif/io_port_with_change_interrupt_tb.sv
// Self-checking bench for the two-port change-interrupt core
`timescale 1ns/1ps
`default_nettype none

`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module io_port_with_change_interrupt_tb;
    import iox_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    iox_wb_req_s req = '0;
    logic [31:0] dat_o;
    logic ack, ia, iao, ib, ibo;
    logic [15:0] pin_in, pin_out, pin_oe, pu_en;
    logic [15:0] ext = 16'h0000;
    logic [15:0] ext_en = 16'hffff;
    logic [31:0] seed = 32'h785d;
    logic [7:0] v, c1;
    int err_count = 0;
    int num_checks = 0;

    // Half period of 20 ns gives 25 MHz
    always #20 clk = ~clk;

    iox_port_irq u_iox_port_irq (.CORE_CLK(clk), .SYS_RST(rst), .WB_REQ(req),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PULLUP_EN(pu_en), .IRQ_A_OUT(ia), .IRQ_A_OE(iao),
        .IRQ_B_OUT(ib), .IRQ_B_OE(ibo));

    iox_pin_pad u_iox_pin_pad (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pu_en(pu_en), .ext_val(ext), .ext_en(ext_en), .pin_in(pin_in));

    // Next random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Pull-up only reaches pins that are inputs
    function automatic logic [7:0] exp_pu(input logic [7:0] pu, input logic [7:0] dir);
        return pu & dir;
    endfunction : exp_pu

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Classic single cycle; held until ack is seen at a rising edge
    task automatic wb(input logic [31:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
        @(posedge clk);
        // Only ack or the watchdog ends a wait for ack
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = dat_o[7:0];
        req <= '0;
    endtask : wb

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(a, 1'b0, 8'h00, q);
        `CK(q, e)
    endtask : rdc

    task automatic pins(input logic [15:0] x);
        @(posedge clk);
        ext <= x;
        repeat (8) @(posedge clk);
    endtask : pins

    // Cuts a hung run short
    initial begin
        #400000;
        err_count++;
        wrap_up();
    end

    initial begin
        seed = lfsr(seed);
        ext = seed[15:0] & 16'hfefe;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc(32'h18, 8'h00);
        rdc(32'h1c, 8'h00);
        rdc(32'h28, 8'h00);
        rdc(32'h24, ext[7:0]);
        wr(32'h1c, 8'hff);
        rdc(32'h1c, 8'h00);
        rdc(32'h14, 8'h00);
        seed = lfsr(seed);
        v = seed[7:0];
        wr(32'h24, v);
        rdc(32'h28, v);
        wr(32'h28, ~v);
        rdc(32'h28, ~v);
        wr(32'h00, 8'h0f);
        wr(32'h18, 8'hff);
        repeat (2) @(posedge clk);
        `CK(pin_oe[7:0], 8'hf0)
        `CK(pin_out[7:0], ~v)
        `CK(pu_en[7:0], exp_pu(8'hff, 8'h0f))
        rdc(32'h24, {~v[7:4], ext[3:0]});
        // Release the input pins so only the pull-up holds them; let the synchroniser settle
        ext_en <= 16'hfff0;
        repeat (3) @(posedge clk);
        rdc(32'h24, {~v[7:4], 4'hf});
        ext_en <= 16'hffff;
        repeat (3) @(posedge clk);
        // Output pin toggling must not interrupt
        wr(32'h04, 8'h10);
        wr(32'h28, v);
        repeat (8) @(posedge clk);
        `CK(ia, 1'b1)
        wr(32'h04, 8'h00);
        wr(32'h00, 8'hff);
        wr(32'h04, 8'h0f);
        pins(ext ^ 16'h0080);
        `CK(ia, 1'b1)
        pins(ext ^ 16'h0001);
        `CK(ia, 1'b0)
        `CK(ib, 1'b1)
        rdc(32'h1c, 8'h01);
        wr(32'h1c, 8'hfe);
        rdc(32'h1c, 8'h01);
        c1 = ext[7:0];
        wr(32'h24, 8'h00);
        repeat (4) @(posedge clk);
        `CK(ia, 1'b0)
        pins(ext ^ 16'h0002);
        rdc(32'h20, c1);
        rdc(32'h20, ext[7:0]);
        repeat (4) @(posedge clk);
        `CK(ia, 1'b1)
        // Port B compares pin 8 against a default of zero
        wr(32'h48, 8'h00);
        wr(32'h4c, 8'h01);
        wr(32'h44, 8'h01);
        pins(ext | 16'h0100);
        `CK(ib, 1'b0)
        `CK(ia, 1'b1)
        rdc(32'h60, ext[15:8]);
        repeat (4) @(posedge clk);
        `CK(ib, 1'b0)
        wr(32'h10, 8'h40);
        repeat (4) @(posedge clk);
        `CK(ia, 1'b0)
        rdc(32'h24, ext[7:0]);
        repeat (4) @(posedge clk);
        `CK(ia, 1'b0)
        `CK(ib, 1'b0)
        pins(ext ^ 16'h0104);
        rdc(32'h64, ext[15:8]);
        repeat (4) @(posedge clk);
        `CK(ib, 1'b0)
        rdc(32'h24, ext[7:0]);
        repeat (4) @(posedge clk);
        `CK({ia, ib}, 2'b11)
        wr(32'h10, 8'h02);
        repeat (4) @(posedge clk);
        `CK(ia, 1'b0)
        wr(32'h10, 8'h04);
        repeat (4) @(posedge clk);
        `CK(iao, 1'b0)
        pins(ext ^ 16'h0001);
        `CK({iao, ia}, 2'b10)
        `CK(ibo, 1'b0)
        wrap_up();
    end
endmodule : io_port_with_change_interrupt_tb

`default_nettype wire

//--- verif/iox_pin_pad.sv
// Pad model: resolves each pin from the core, an outside driver and the pull-up
`timescale 1ns/1ps
`default_nettype none

module iox_pin_pad (
    // Clock for the floating pattern
    input wire logic clk,
    // Core side
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pu_en,
    // Outside driver
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    // Resolved level back to the core
    output logic [15:0] pin_in
);
    logic [15:0] last_q;

    // Remember the level so a floating pin can wander away from it
    always_ff @(posedge clk) begin
        last_q <= pin_in;
    end

    // Core drive wins, then outside drive, then pull-up, else a toggling float
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pu_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~last_q[i];
            end
        end
    end
endmodule : iox_pin_pad

`default_nettype wire
